// >>> rtl/framer_common_control.sv
// per-framer common control and status bank on a Wishbone slave
`timescale 1ns/1ps
// Behaviour
// - soft reset returns every bank register but itself to default
// - soft reset bit OR external reset pin resets the framer
// - disable bit stops the framer clocks
// - soft reset while disabled re-enables the framer
// - unframed all ones sent while its bit is set and line loopback is off; set after reset
// - auto mode updates counters each second and latches the flag
// - manual mode updates on rise of manual bit OR update pin
// - manual bit ignored in auto mode; clear and set per update
// - binary bit picks dual rail or single rail with violations
// - substitution off when disabled bit set or binary mode
// - tx clock loss flagged; switch to rx clock and AIS if enabled
// - payload loopback: formatter on rx clock with received payload
// - line loopback drives tx line from rx line
// - diagnostic loopback feeds receiver from formatter pre-AIS tap
// - constant clock select overrides enable mode, keeps inversion
// - second timer counts rx clock at 0, tx input clock at 1
// - read-only device code at index zero
// - diagnostic loopback wins over payload loopback
// - data enable high in payload bit times, low in overhead
module framer_common_control #(
  parameter logic [7:0] DEVICE_CODE  = 8'h5a, // value is arbitrary
  parameter int         SECOND_TICKS = 44736000,
  parameter int         LOSS_CYCLES  = 64
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire framer_ctl_pkg::wbReq_t wbReq,
  output logic                        wbAck,
  output logic [31:0]                 wbDatOut,
  input  wire logic                   txInputClockPin,
  input  wire logic                   rxLineClockPin,
  input  wire framer_ctl_pkg::rail_t  rxLinePin,
  input  wire logic                   framerResetPin,
  input  wire logic                   countUpdateInPin,
  input  wire framer_ctl_pkg::rail_t  fmtLine,
  input  wire framer_ctl_pkg::rail_t  aisLine,
  input  wire logic                   payloadSlot,
  output framer_ctl_pkg::rail_t       txLine,
  output logic                        txLineClock,
  output framer_ctl_pkg::rail_t       rxFramerIn,
  output logic                        txEnableOrGappedClock,
  output logic                        framerReset,
  output logic                        framerClockEnable,
  output logic                        countUpdate,
  output logic                        binaryLineMode,
  output logic                        substEnable,
  output logic                        aisInsert,
  output logic                        txClockFromRx,
  output logic                        payloadFromRx,
  output logic                        rxDataForceHigh
);
  import framer_ctl_pkg::*;
  `include "framer_ctl_params.svh"

  localparam int SEC_W    = $clog2(SECOND_TICKS);
  localparam int LOSS_W   = $clog2(LOSS_CYCLES + 1);
  localparam int UPD_WAIT = `UPDATE_WAIT_CYC;

  // the second and loss counters need room for a real count
  if (SECOND_TICKS < 2 || LOSS_CYCLES < 4) begin : g_bad_counts
    $error("framer_common_control: counts too small");
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  logic [1:0]       clkHist;

  assign pinRaw = {countUpdateInPin, framerResetPin, rxLinePin.neg,
                   rxLinePin.pos, rxLineClockPin, txInputClockPin};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
        end else begin
          syncA[gi] <= pinRaw[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      clkHist <= 2'h0;
    else
      clkHist <= syncB[1:0];
  end

  wire txClkS = syncB[0];
  wire rxClkS = syncB[1];
  wire rstPinS = syncB[4];
  wire updPinS = syncB[5];
  wire txRise = txClkS & ~clkHist[0];
  wire rxRise = rxClkS & ~clkHist[1];
  wire txEdge = txClkS ^ clkHist[0];
  rail_t rxLineS;
  assign rxLineS.pos = syncB[2];
  assign rxLineS.neg = syncB[3];

  // ************************************************************
  // register bank and wishbone slave
  // ************************************************************
  logic [7:0] cfgOne;
  logic [7:0] cfgTwo;
  logic [7:0] cfgThree;
  logic [7:0] rxPinCfg;
  logic [7:0] linePinCfg;
  logic [7:0] statusLatched;
  logic [7:0] statusIrqEn;
  busState_t  busState;
  logic       lossFlag;
  logic       flagSetQ;

  wire       busReq  = wbReq.cyc & wbReq.stb & (busState == BUS_IDLE);
  wire [3:0] idx     = wbReq.adr[5:2];
  wire       inRange = (wbReq.adr[7:6] == 2'h0) & (wbReq.adr[1:0] == 2'h0);
  wire       wrEn    = busReq & wbReq.we & wbReq.sel[0] & inRange;
  wire [7:0] wrByte  = wbReq.dat[7:0];
  // soft reset bit OR pin
  wire       frameRst = cfgOne[`F_SOFT_RESET] | rstPinS;

  function automatic logic hit(input logic [3:0] i, input logic [3:0] r);
    hit = (i == r);
  endfunction

  wire wrOne   = wrEn & hit(idx, `IDX_CONFIG_ONE);
  wire wrTwo   = wrEn & hit(idx, `IDX_CONFIG_TWO);
  wire wrThree = wrEn & hit(idx, `IDX_CONFIG_THREE);
  wire wrRxPin = wrEn & hit(idx, `IDX_RX_PIN_CFG);
  wire wrLine  = wrEn & hit(idx, `IDX_LINE_PIN_CFG);
  wire wrLatch = wrEn & hit(idx, `IDX_STATUS_LATCH);
  wire wrIrqEn = wrEn & hit(idx, `IDX_STATUS_IRQ_EN);

  wire [7:0] statusLive = {1'b0, lossFlag, 6'h00};
  logic [7:0] rdByte;
  always_comb begin
    if (!inRange)
      rdByte = 8'h00;
    else if (hit(idx, `IDX_DEVICE_CODE))
      rdByte = DEVICE_CODE;
    else if (hit(idx, `IDX_CONFIG_ONE))
      rdByte = cfgOne;
    else if (hit(idx, `IDX_CONFIG_TWO))
      rdByte = cfgTwo & `MASK_CONFIG_TWO;
    else if (hit(idx, `IDX_CONFIG_THREE))
      rdByte = cfgThree;
    else if (hit(idx, `IDX_RX_PIN_CFG))
      rdByte = rxPinCfg;
    else if (hit(idx, `IDX_LINE_PIN_CFG))
      rdByte = linePinCfg;
    else if (hit(idx, `IDX_STATUS_LIVE))
      rdByte = statusLive;
    else if (hit(idx, `IDX_STATUS_LATCH))
      rdByte = statusLatched;
    else if (hit(idx, `IDX_STATUS_IRQ_EN))
      rdByte = statusIrqEn;
    else
      rdByte = 8'h00;
  end

  // one wait-free answer, then ack drops for a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busState <= BUS_IDLE;
      wbAck    <= 1'b0;
      wbDatOut <= 32'h0;
    end else begin
      busState <= busReq ? BUS_ACK : BUS_IDLE;
      wbAck    <= busReq;
      if (busReq)
        wbDatOut <= {24'h0, rdByte};
    end
  end

  // framer reset also re-enables a disabled framer; the soft bit stays
  // writable during it, else software could never release the reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgOne      <= `RST_CONFIG_ONE;
      cfgTwo      <= `RST_CONFIG_TWO;
      cfgThree    <= `RST_CONFIG_THREE;
      rxPinCfg    <= `RST_RX_PIN_CFG;
      linePinCfg  <= `RST_LINE_PIN_CFG;
      statusIrqEn <= `RST_IRQ_EN;
    end else if (frameRst) begin
      cfgOne[7:1] <= 7'(`RST_CONFIG_ONE >> 1);
      if (wrOne)
        cfgOne[`F_SOFT_RESET] <= wrByte[`F_SOFT_RESET];
      cfgTwo      <= `RST_CONFIG_TWO;
      cfgThree    <= `RST_CONFIG_THREE;
      rxPinCfg    <= `RST_RX_PIN_CFG;
      linePinCfg  <= `RST_LINE_PIN_CFG;
      statusIrqEn <= `RST_IRQ_EN;
    end else begin
      if (wrOne)
        cfgOne <= wrByte;
      if (wrTwo)
        cfgTwo <= wrByte & `MASK_CONFIG_TWO;
      if (wrThree)
        cfgThree <= wrByte;
      if (wrRxPin)
        rxPinCfg <= wrByte;
      if (wrLine)
        linePinCfg <= wrByte;
      if (wrIrqEn)
        statusIrqEn <= wrByte;
    end
  end

  // latched status: write one to clear, a new event wins over the clear
  wire [7:0] latchSet = {1'b0, lossFlag, 5'h00, flagSetQ};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      statusLatched <= 8'h00;
    else if (frameRst)
      statusLatched <= 8'h00;
    else
      statusLatched <= (statusLatched & ~(wrLatch ? wrByte : 8'h00))
                       | latchSet;
  end

  // ************************************************************
  // one-second timer, counter update and clock loss
  // ************************************************************
  wire        run     = ~cfgOne[`F_DISABLE];
  wire        secEdge = run & (cfgTwo[`F_SEC_CLK_SEL] ? txRise : rxRise);
  logic [SEC_W-1:0] secCount;
  logic [LOSS_W-1:0] lossCount;
  logic       trigQ;

  wire secTick = secEdge &
                 (secCount == SEC_W'(SECOND_TICKS - 1));
  wire autoTick = secTick & ~cfgOne[`F_AUTO_DEFEAT];
  // manual bit only counts in manual mode
  wire trig = (cfgOne[`F_MANUAL_UPD] | updPinS) &
              cfgOne[`F_AUTO_DEFEAT];
  wire manTick = run & trig & ~trigQ;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secCount <= '0;
      trigQ    <= 1'b0;
    end else if (frameRst) begin
      secCount <= '0;
      trigQ    <= 1'b0;
    end else begin
      trigQ <= trig;
      if (secTick)
        secCount <= '0;
      else if (secEdge)
        secCount <= secCount + SEC_W'(1);
    end
  end

  // update leaves as one pulse; the flag follows a cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countUpdate <= 1'b0;
      flagSetQ    <= 1'b0;
    end else begin
      countUpdate <= autoTick | manTick;
      flagSetQ    <= autoTick;
    end
  end

  // loss is declared after LOSS_CYCLES + 1 system clocks without an edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lossCount <= '0;
      lossFlag  <= 1'b0;
    end else if (txEdge || !run) begin
      lossCount <= '0;
      lossFlag  <= 1'b0;
    end else if (lossCount == LOSS_W'(LOSS_CYCLES)) begin
      lossFlag  <= 1'b1;
    end else begin
      lossCount <= lossCount + LOSS_W'(1);
    end
  end

  // ************************************************************
  // line steering and registered outputs
  // ************************************************************
  wire switchToRx = lossFlag & cfgOne[`F_LOSS_SWITCH];
  wire plbActive  = cfgTwo[`F_PAYLOAD_LB] & ~cfgTwo[`F_DIAG_LB];
  wire txClkUse   = cfgTwo[`F_LINE_LB] | plbActive | switchToRx;
  wire txClkSel   = txClkUse ? rxClkS : txClkS;
  // constant clock wins over the enable mode; inversion still applies
  wire enMode = cfgThree[`F_ENABLE_MODE] ? (payloadSlot & txClkSel)
                                         : payloadSlot;
  wire enRaw  = cfgTwo[`F_CONST_CLK] ? txClkSel : enMode;
  logic  onesPhase;
  rail_t next_txLine;
  rail_t next_rxFramer;

  framer_line_mux u_line_mux (
    .rxLine        (rxLineS),
    .fmtLine       (fmtLine),
    .aisLine       (aisLine),
    .onesPhase     (onesPhase),
    .cfgOne        (cfgOne),
    .cfgTwo        (cfgTwo),
    .linePinCfg    (linePinCfg),
    .aisInsert     (switchToRx),
    .next_txLine   (next_txLine),
    .next_rxFramer (next_rxFramer)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      onesPhase <= 1'b0;
      txLine    <= '0;
      rxFramerIn <= '0;
    end else if (run) begin
      if (txRise)
        onesPhase <= ~onesPhase;
      txLine     <= next_txLine;
      rxFramerIn <= next_rxFramer;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txLineClock           <= 1'b0;
      txEnableOrGappedClock <= 1'b0;
      framerReset           <= 1'b0;
      framerClockEnable     <= 1'b0;
      binaryLineMode        <= 1'b0;
      substEnable           <= 1'b0;
      aisInsert             <= 1'b0;
      txClockFromRx         <= 1'b0;
      payloadFromRx         <= 1'b0;
      rxDataForceHigh       <= 1'b1;
    end else begin
      txLineClock           <= txClkSel ^ linePinCfg[`F_TXCLK_INV];
      txEnableOrGappedClock <= enRaw ^ cfgThree[`F_ENABLE_INV];
      framerReset           <= frameRst;
      framerClockEnable     <= run;
      binaryLineMode        <= cfgOne[`F_BINARY];
      substEnable           <= ~cfgOne[`F_BINARY] &
                               ~cfgOne[`F_ZERO_SUB_DIS];
      aisInsert             <= switchToRx;
      txClockFromRx         <= txClkUse;
      payloadFromRx         <= plbActive;
      rxDataForceHigh       <= rxPinCfg[`F_RXDATA_HIGH];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  a_soft_reset_defaults: assert property (
    @(posedge clk) disable iff (!rst_n)
    frameRst |=> ((cfgOne & 8'hfe) == (`RST_CONFIG_ONE & 8'hfe))
                 && cfgTwo == `RST_CONFIG_TWO && statusLatched == 8'h00)
    else $error("soft reset left a register off its default");

  a_reset_or_pin: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rstPinS || cfgOne[`F_SOFT_RESET]) |=> framerReset)
    else $error("framer reset output missed a reset source");

  a_disable_stops: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfgOne[`F_DISABLE] |=> !framerClockEnable && !countUpdate)
    else $error("disabled framer still clocked");

  a_reset_reenables: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfgOne[`F_DISABLE] && frameRst) |=> !cfgOne[`F_DISABLE])
    else $error("soft reset did not re-enable framer");

  a_unframed_ones: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfgOne[`F_UNFRAMED_ONES] && cfgOne[`F_BINARY] && run
     && !cfgTwo[`F_LINE_LB] && linePinCfg == 8'h00) |=> txLine.pos)
    else $error("all ones not on the binary output");

  a_auto_update: assert property (
    @(posedge clk) disable iff (!rst_n)
    (autoTick && !frameRst) |=> countUpdate ##1 statusLatched[`F_ONE_SEC])
    else $error("one-second update or flag missing");

  a_manual_update: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfgOne[`F_AUTO_DEFEAT] && run && !frameRst && $rose(updPinS)
     && !cfgOne[`F_MANUAL_UPD] && !$past(cfgOne[`F_MANUAL_UPD]))
    |-> ##[1:UPD_WAIT] countUpdate)
    else $error("manual update pulse missing");

  a_manual_ignored: assert property (
    @(posedge clk) disable iff (!rst_n)
    (countUpdate && !$past(cfgOne[`F_AUTO_DEFEAT])) |-> $past(secTick))
    else $error("update outside the second boundary in auto mode");

  a_binary_no_subst: assert property (
    @(posedge clk) disable iff (!rst_n)
    cfgOne[`F_BINARY] |=> !substEnable)
    else $error("substitution enabled in binary mode");

  a_loss_switch: assert property (
    @(posedge clk) disable iff (!rst_n)
    (lossFlag && cfgOne[`F_LOSS_SWITCH]) |=> aisInsert && txClockFromRx)
    else $error("clock loss did not switch to receive clock");

  a_diag_priority: assert property (
    @(posedge clk) disable iff (!rst_n)
    (cfgTwo[`F_PAYLOAD_LB] && cfgTwo[`F_DIAG_LB]) |=> !payloadFromRx)
    else $error("payload loopback active under diagnostic loopback");

  a_unused_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (busReq && !wbReq.we && inRange && hit(idx, `IDX_CONFIG_TWO))
    |=> wbAck && wbDatOut[5:3] == 3'h0)
    else $error("unused configuration bits read non-zero");
endmodule

// >>> include/framer_ctl_params.svh
// offsets, field positions, reset values and timing counts of the framer bank
`ifndef FRAMER_CTL_PARAMS_SVH
`define FRAMER_CTL_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_DEVICE_CODE   4'h0
`define IDX_CONFIG_ONE    4'h1
`define IDX_CONFIG_TWO    4'h2
`define IDX_CONFIG_THREE  4'h3
`define IDX_RX_PIN_CFG    4'h4
`define IDX_LINE_PIN_CFG  4'h5
`define IDX_FRAMER_SUMMARY 4'h6
`define IDX_STATUS_LIVE   4'h8
`define IDX_STATUS_LATCH  4'h9
`define IDX_STATUS_IRQ_EN 4'ha

// first configuration register fields
`define F_SOFT_RESET    0
`define F_DISABLE       1
`define F_UNFRAMED_ONES 2
`define F_AUTO_DEFEAT   3
`define F_MANUAL_UPD    4
`define F_BINARY        5
`define F_ZERO_SUB_DIS  6
`define F_LOSS_SWITCH   7
// second configuration register fields
`define F_PAYLOAD_LB    0
`define F_LINE_LB       1
`define F_DIAG_LB       2
`define F_CONST_CLK     6
`define F_SEC_CLK_SEL   7
// third configuration register fields
`define F_ENABLE_INV    0
`define F_ENABLE_MODE   7
// receive pin configuration field
`define F_RXDATA_HIGH   4
// line pin configuration fields
`define F_TXCLK_INV     0
`define F_TXPOS_INV     1
`define F_TXNEG_INV     2
`define F_TXPOS_HIGH    3
`define F_TXNEG_HIGH    4
`define F_RXCLK_INV     5
`define F_RXPOS_INV     6
`define F_RXNEG_INV     7
// status fields
`define F_ONE_SEC       0
`define F_TXCLK_LOSS    6

// reset values and writable masks
`define RST_CONFIG_ONE   8'h04
`define RST_CONFIG_TWO   8'h00
`define RST_CONFIG_THREE 8'h00
`define RST_RX_PIN_CFG   8'h10
`define RST_LINE_PIN_CFG 8'h00
`define RST_IRQ_EN       8'h00
`define MASK_CONFIG_TWO  8'hc7

// timing
`define CLK_PERIOD_NS    8
`define UPDATE_WAIT_NS   100
`define UPDATE_WAIT_CYC  (`UPDATE_WAIT_NS / `CLK_PERIOD_NS)

`endif

// >>> include/framer_ctl_pkg.sv
// types shared by the framer control bank and its line selector
package framer_ctl_pkg;

  typedef struct packed {
    logic pos;
    logic neg;
  } rail_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wbReq_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } busState_t;

endpackage

// >>> rtl/framer_line_mux.sv
// line data steering: loopbacks, all-ones and AIS insertion, pin polarity
`timescale 1ns/1ps
module framer_line_mux (
  input  wire framer_ctl_pkg::rail_t rxLine,
  input  wire framer_ctl_pkg::rail_t fmtLine,
  input  wire framer_ctl_pkg::rail_t aisLine,
  input  wire logic                  onesPhase,
  input  wire logic [7:0]            cfgOne,
  input  wire logic [7:0]            cfgTwo,
  input  wire logic [7:0]            linePinCfg,
  input  wire logic                  aisInsert,
  output framer_ctl_pkg::rail_t      next_txLine,
  output framer_ctl_pkg::rail_t      next_rxFramer
);
  import framer_ctl_pkg::*;
  `include "framer_ctl_params.svh"

  rail_t onesLine;
  rail_t rxPol;
  rail_t txSel;

  // binary mode carries all ones on one wire; dual rail alternates marks
  assign onesLine.pos = cfgOne[`F_BINARY] ? 1'b1 : onesPhase;
  assign onesLine.neg = cfgOne[`F_BINARY] ? 1'b0 : ~onesPhase;

  assign rxPol.pos = rxLine.pos ^ linePinCfg[`F_RXPOS_INV];
  assign rxPol.neg = rxLine.neg ^ linePinCfg[`F_RXNEG_INV];

  // line loopback overrides everything the formatter produces
  assign txSel = cfgTwo[`F_LINE_LB]       ? rxPol :
                 cfgOne[`F_UNFRAMED_ONES] ? onesLine :
                 aisInsert                ? aisLine :
                                            fmtLine;

  // force high ahead of inversion so both together force low
  assign next_txLine.pos = (txSel.pos | linePinCfg[`F_TXPOS_HIGH])
                           ^ linePinCfg[`F_TXPOS_INV];
  assign next_txLine.neg = (txSel.neg | linePinCfg[`F_TXNEG_HIGH])
                           ^ linePinCfg[`F_TXNEG_INV];

  // diagnostic tap sits before AIS, all ones, force-high and inversion
  assign next_rxFramer = cfgTwo[`F_DIAG_LB] ? fmtLine : rxPol;
endmodule

// >>> verification/test_framer_common_control.sv
// self-checking bench for the framer common control bank
`timescale 1ns/1ps
module test_framer_common_control;
  import framer_ctl_pkg::*;
  localparam logic [7:0] CODE = 8'h3c; // value is arbitrary
  logic        clk = 0, rst_n = 0, txRun = 1;
  logic        txInputClockPin = 0, rxLineClockPin = 0;
  logic        framerResetPin = 0, countUpdateInPin = 0, payloadSlot = 0;
  wbReq_t      wbReq = '0;
  rail_t       rxLinePin = '0, fmtLine = '0, aisLine = '0;
  rail_t       txLine, rxFramerIn;
  logic        wbAck, txLineClock, txEnableOrGappedClock, framerReset;
  logic        framerClockEnable, countUpdate, binaryLineMode, substEnable;
  logic        aisInsert, txClockFromRx, payloadFromRx, rxDataForceHigh;
  logic [31:0] wbDatOut;
  logic [1:0]  div = 0;
  logic [7:0]  q;
  int          errors = 0, tests_run = 0, updates = 0, base, highs;
  logic [3:0]  idxT [9] = '{0, 1, 2, 3, 4, 5, 6, 10, 11};
  logic [7:0]  rstT [9] = '{CODE, 8'h04, 0, 0, 8'h10, 0, 0, 0, 0};
  logic [7:0]  modeT [4] = '{8'h00, 8'h40, 8'h20, 8'h60};
  logic [7:0]  expT [4] = '{8'h01, 8'h00, 8'h02, 8'h02};

  framer_common_control #(.DEVICE_CODE(CODE), .SECOND_TICKS(8),
                          .LOSS_CYCLES(8)) framer_common_control_inst (
    .clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbAck(wbAck),
    .wbDatOut(wbDatOut), .txInputClockPin(txInputClockPin),
    .rxLineClockPin(rxLineClockPin), .rxLinePin(rxLinePin),
    .framerResetPin(framerResetPin), .countUpdateInPin(countUpdateInPin),
    .fmtLine(fmtLine), .aisLine(aisLine), .payloadSlot(payloadSlot),
    .txLine(txLine), .txLineClock(txLineClock), .rxFramerIn(rxFramerIn),
    .txEnableOrGappedClock(txEnableOrGappedClock),
    .framerReset(framerReset), .framerClockEnable(framerClockEnable),
    .countUpdate(countUpdate), .binaryLineMode(binaryLineMode),
    .substEnable(substEnable), .aisInsert(aisInsert),
    .txClockFromRx(txClockFromRx), .payloadFromRx(payloadFromRx),
    .rxDataForceHigh(rxDataForceHigh));

  always #4 clk = ~clk;

  // line clocks run at a quarter of clk; the tx one can be stopped
  always @(posedge clk) begin
    div <= div + 2'h1;
    rxLineClockPin <= div[1];
    if (txRun) txInputClockPin <= div[1];
    if (countUpdate === 1'b1) updates <= updates + 1;
  end

  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic acc(input logic w, input logic [3:0] idx,
                     input logic [7:0] d);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {2'b00, idx, 2'b00},
               sel: 4'hf, dat: {24'h0, d}};
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    q = wbDatOut[7:0];
    wbReq <= '0;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    acc(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
    acc(1'b0, idx, 8'h00);
    chk(q, exp);
  endtask

  task give_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rdchk(idxT[i], rstT[i]);
    wr(0, 8'hff);
    rdchk(0, CODE);
    wr(2, 8'hff);
    rdchk(2, 8'hc7);
    wr(2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(1, modeT[i]);
      repeat (2) @(posedge clk);
      chk({6'h0, binaryLineMode, substEnable}, expT[i]);
    end
    wr(1, 8'h24);
    repeat (20) @(posedge clk);
    chk({6'h0, txLine}, 8'h02);
    wr(1, 8'h00);
    wr(9, 8'hff);
    base = updates;
    repeat (100) @(posedge clk);
    chk({7'h0, updates > base}, 8'h01);
    acc(1'b0, 9, 8'h00);
    chk(q & 8'h01, 8'h01);
    // manual mode: only a fresh rise of bit OR pin counts
    wr(1, 8'h08);
    repeat (40) @(posedge clk);
    base = updates;
    wr(1, 8'h18);
    repeat (13) @(posedge clk);
    chk(8'(updates - base), 8'h01);
    wr(1, 8'h18);
    repeat (13) @(posedge clk);
    chk(8'(updates - base), 8'h01);
    wr(1, 8'h08);
    wr(1, 8'h18);
    repeat (13) @(posedge clk);
    chk(8'(updates - base), 8'h02);
    wr(1, 8'h08);
    countUpdateInPin <= 1'b1;
    repeat (13) @(posedge clk);
    chk(8'(updates - base), 8'h03);
    countUpdateInPin <= 1'b0;
    wr(1, 8'h80);
    txRun <= 1'b0;
    repeat (30) @(posedge clk);
    acc(1'b0, 8, 8'h00);
    chk(q & 8'h40, 8'h40);
    chk({6'h0, aisInsert, txClockFromRx}, 8'h03);
    highs = 0;
    repeat (16) begin
      @(posedge clk);
      highs += int'(txLineClock === 1'b1);
    end
    chk({7'h0, highs > 2 && highs < 14}, 8'h01);
    wr(2, 8'h80);
    repeat (4) @(posedge clk);
    base = updates;
    repeat (100) @(posedge clk);
    chk(8'(updates - base), 8'h00);
    txRun <= 1'b1;
    repeat (100) @(posedge clk);
    chk({7'h0, updates > base}, 8'h01);
    chk({7'h0, aisInsert}, 8'h00);
    wr(2, 8'h07);
    wr(4, 8'h00);
    wr(1, 8'h02);
    repeat (2) @(posedge clk);
    chk({7'h0, framerClockEnable}, 8'h00);
    chk({7'h0, rxDataForceHigh}, 8'h00);
    wr(1, 8'h03);
    repeat (2) @(posedge clk);
    chk({7'h0, framerReset}, 8'h01);
    repeat (13) @(posedge clk);
    wr(1, 8'h00);
    rdchk(1, 8'h04);
    rdchk(2, 8'h00);
    rdchk(4, 8'h10);
    chk({7'h0, rxDataForceHigh}, 8'h01);
    chk({7'h0, framerClockEnable}, 8'h01);
    framerResetPin <= 1'b1;
    repeat (4) @(posedge clk);
    chk({7'h0, framerReset}, 8'h01);
    framerResetPin <= 1'b0;
    repeat (4) @(posedge clk);
    wr(1, 8'h00);
    rxLinePin <= '{pos: 1'b1, neg: 1'b0};
    wr(2, 8'h02);
    repeat (20) @(posedge clk);
    chk({6'h0, txLine}, 8'h02);
    rxLinePin <= '{pos: 1'b0, neg: 1'b1};
    repeat (20) @(posedge clk);
    chk({6'h0, txLine}, 8'h01);
    fmtLine <= '{pos: 1'b1, neg: 1'b1};
    wr(2, 8'h04);
    repeat (20) @(posedge clk);
    chk({6'h0, rxFramerIn}, 8'h03);
    wr(2, 8'h05);
    repeat (3) @(posedge clk);
    chk({7'h0, payloadFromRx}, 8'h00);
    wr(2, 8'h01);
    repeat (3) @(posedge clk);
    chk({7'h0, payloadFromRx}, 8'h01);
    wr(2, 8'h00);
    payloadSlot <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h0, txEnableOrGappedClock}, 8'h01);
    payloadSlot <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h0, txEnableOrGappedClock}, 8'h00);
    wr(2, 8'h40);
    highs = 0;
    repeat (16) begin
      @(posedge clk);
      highs += int'(txEnableOrGappedClock === 1'b1);
    end
    chk({7'h0, highs > 2 && highs < 14}, 8'h01);
    give_verdict;
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict;
  end
endmodule
